// [logic/rtcio_pkg.sv]
// constants and carrier types for the rtc interrupt and clock-out logic
`default_nettype none

package rtcio_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int LAG_32768_NS  = 92000;
  localparam int LAG_32000_NS  = 94000;
  localparam logic [11:0] LAG_32768_CYC =
    12'(LAG_32768_NS / CLK_PERIOD_NS);
  localparam logic [11:0] LAG_32000_CYC =
    12'(LAG_32000_NS / CLK_PERIOD_NS);
  localparam logic [11:0] LAG_CNT_ZERO  = 12'h000;
  localparam logic [11:0] LAG_CNT_ONE   = 12'h001;

  // ------------------------------------------------------------------
  // control register 1 (Eh) bit positions
  // ------------------------------------------------------------------
  localparam int CTRL1_ALARM_A_EN_BIT = 7;
  localparam int CTRL1_ALARM_B_EN_BIT = 6;
  localparam int CTRL1_CYCLE_SEL_HI   = 2;
  localparam int CTRL1_CYCLE_SEL_LO   = 0;

  // ------------------------------------------------------------------
  // control register 2 (Fh) bit positions
  // ------------------------------------------------------------------
  localparam int CTRL2_CLK_OUT_DIS_BIT = 3;
  localparam int CTRL2_PERIODIC_BIT    = 2;
  localparam int CTRL2_ALARM_A_BIT     = 1;
  localparam int CTRL2_ALARM_B_BIT     = 0;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ------------------------------------------------------------------
  // periodic cycle select codes
  // ------------------------------------------------------------------
  localparam logic [2:0] CS_OFF   = 3'h0;
  localparam logic [2:0] CS_LOW   = 3'h1;
  localparam logic [2:0] CS_2HZ   = 3'h2;
  localparam logic [2:0] CS_1HZ   = 3'h3;
  localparam logic [2:0] CS_SEC   = 3'h4;
  localparam logic [2:0] CS_MIN   = 3'h5;
  localparam logic [2:0] CS_HOUR  = 3'h6;
  localparam logic [2:0] CS_MONTH = 3'h7;

  // ------------------------------------------------------------------
  // calendar compare values
  // ------------------------------------------------------------------
  localparam logic [6:0] SEC_ZERO   = 7'h00;
  localparam logic [6:0] MIN_ZERO   = 7'h00;
  localparam logic [5:0] HOUR_ZERO  = 6'h00;
  localparam logic [5:0] MDAY_FIRST = 6'h01;
  localparam logic [1:0] QTR_FIRST  = 2'h0;
  localparam logic [1:0] QTR_STEP   = 2'h1;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] dow;
    logic [5:0] mday;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } rtcio_cal_s;

  typedef struct packed {
    logic [2:0] dow;
    logic [5:0] hour;
    logic [6:0] min;
  } rtcio_alarm_s;

  typedef struct packed {
    logic       alarm_a_enable;
    logic       alarm_b_enable;
    logic [2:0] periodic_cycle_select;
    logic       clock_output_disable;
  } rtcio_cfg_s;

  typedef struct packed {
    logic alarm_a_event_flag;
    logic alarm_b_event_flag;
    logic periodic_event_flag;
  } rtcio_flags_s;

  typedef enum logic [1:0] {
    RTCIO_LAG_IDLE = 2'b01,
    RTCIO_LAG_WAIT = 2'b10
  } rtcio_lag_e;

endpackage : rtcio_pkg

`default_nettype wire

// [logic/rtcio_top.sv]
// interrupt output and raw clock output logic of the rtc
// ------------------------------------------------------------------
// What this block does
// - enabled alarm match pulls interrupt low
// - alarm flags Fh D1/D0, enables Eh D7/D6
// - periodic flag Fh D2, select 000 disables
// - halt flag clears enables and select
// - any active source pulls shared pin low
// - host reads flags to find source
// - alarm flag reads inverse of output level
// - codes off, fixed low, 2Hz, 1Hz
// - level codes: second, minute, hour, month
// - level mode falls with seconds increment
// - 32.000 kHz gives 0.496/0.504 s halves
// - trimming shifts periodic timing every 20 s
// - pulse edge lags seconds by 92/94 us
// - disable bit stops raw clock, pin high
// - raw clock output is untrimmed oscillator
// - raw clock output on after halt power-up
// - level mode holds until flag written 0
// ------------------------------------------------------------------
`default_nettype none

module rtcio_top (
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  input  wire logic                           oscillator_halt_flag,
  input  wire logic                           xtal_32000,
  input  wire logic                           osc_clk_pin,
  input  wire logic                           sec_tick,
  input  wire logic                           quarter_tick,
  input  wire rtcio_pkg::rtcio_cal_s          cal_now,
  input  wire rtcio_pkg::rtcio_alarm_s        alarm_a_time,
  input  wire rtcio_pkg::rtcio_alarm_s        alarm_b_time,
  input  wire logic                           ctrl1_wr,
  input  wire logic [7:0]                     ctrl1_wdata,
  input  wire logic                           ctrl2_wr,
  input  wire logic [7:0]                     ctrl2_wdata,
  output var  logic [7:0]                     ctrl1_rdata_q,
  output var  logic [7:0]                     ctrl2_rdata_q,
  output var  rtcio_pkg::rtcio_flags_s        flags_q,
  output var  logic                           interrupt_out_n_q,
  output var  logic                           interrupt_oe_n_q,
  output var  logic                           raw_clock_out_q
);
  import rtcio_pkg::*;

  // ------------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------------
  rtcio_cfg_s cfg_q;
  rtcio_cfg_s cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (ctrl1_wr) begin
      cfg_d.alarm_a_enable        = ctrl1_wdata[CTRL1_ALARM_A_EN_BIT];
      cfg_d.alarm_b_enable        = ctrl1_wdata[CTRL1_ALARM_B_EN_BIT];
      cfg_d.periodic_cycle_select =
        ctrl1_wdata[CTRL1_CYCLE_SEL_HI:CTRL1_CYCLE_SEL_LO];
    end
    if (ctrl2_wr) begin
      cfg_d.clock_output_disable = ctrl2_wdata[CTRL2_CLK_OUT_DIS_BIT];
    end
    if (oscillator_halt_flag) begin
      cfg_d = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ------------------------------------------------------------------
  // flag write decode (write 0 clears, write 1 keeps)
  // ------------------------------------------------------------------
  wire       clr_a_w   = ctrl2_wr & ~ctrl2_wdata[CTRL2_ALARM_A_BIT];
  wire       clr_b_w   = ctrl2_wr & ~ctrl2_wdata[CTRL2_ALARM_B_BIT];
  wire       clr_per_w = ctrl2_wr & ~ctrl2_wdata[CTRL2_PERIODIC_BIT];
  wire [1:0] alarm_en_w;
  wire [1:0] alarm_clr_w;
  wire [1:0] alarm_flag_w;
  rtcio_alarm_s alarm_time_w [2];

  assign alarm_en_w   = {cfg_q.alarm_b_enable, cfg_q.alarm_a_enable};
  assign alarm_clr_w  = {clr_b_w, clr_a_w};
  assign alarm_time_w[0] = alarm_a_time;
  assign alarm_time_w[1] = alarm_b_time;

  // ------------------------------------------------------------------
  // alarm comparators, index 0 is alarm a, index 1 is alarm b
  // ------------------------------------------------------------------
  for (genvar gi = 0; gi < 2; gi++) begin : g_alarm
    logic match_q;
    logic flag_q;
    logic flag_d;
    wire  match_w;

    assign match_w = alarm_en_w[gi]
                   & (alarm_time_w[gi].dow  == cal_now.dow)
                   & (alarm_time_w[gi].hour == cal_now.hour)
                   & (alarm_time_w[gi].min  == cal_now.min);

    always_comb begin
      flag_d = flag_q;
      if (alarm_clr_w[gi]) begin
        flag_d = 1'b0;
      end
      if (!alarm_en_w[gi]) begin
        flag_d = 1'b0;
      end
      if (match_w && !match_q) begin
        flag_d = 1'b1;
      end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        match_q <= 1'b0;
        flag_q  <= 1'b0;
      end else begin
        match_q <= match_w;
        flag_q  <= flag_d;
      end
    end

    assign alarm_flag_w[gi] = flag_q;
  end

  // ------------------------------------------------------------------
  // pulse mode: quarter index and lag on both edges
  // ------------------------------------------------------------------
  // quarter ticks from prescaler
  logic [1:0]  qtr_q;
  logic [1:0]  pend_qtr_q;
  logic [11:0] lag_cnt_q;
  logic        wave_low_q;
  rtcio_lag_e  lag_q;
  rtcio_lag_e  lag_d;

  wire [11:0] lag_len_w  = xtal_32000 ? LAG_32000_CYC : LAG_32768_CYC;
  wire [1:0]  qtr_next_w = sec_tick ? QTR_FIRST : qtr_q + QTR_STEP;
  wire [2:0]  cs_w       = cfg_q.periodic_cycle_select;
  wire        lag_done_w = (lag_q == RTCIO_LAG_WAIT)
                         & (lag_cnt_q == LAG_CNT_ONE);
  wire        low_2hz_w  = ~pend_qtr_q[0];
  wire        low_1hz_w  = ~pend_qtr_q[1];

  always_comb begin
    case (lag_q)
      RTCIO_LAG_IDLE: begin
        lag_d = quarter_tick ? RTCIO_LAG_WAIT : RTCIO_LAG_IDLE;
      end
      RTCIO_LAG_WAIT: begin
        if (quarter_tick) begin
          lag_d = RTCIO_LAG_WAIT;
        end else if (lag_done_w) begin
          lag_d = RTCIO_LAG_IDLE;
        end else begin
          lag_d = RTCIO_LAG_WAIT;
        end
      end
      default: begin
        lag_d = RTCIO_LAG_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lag_q <= RTCIO_LAG_IDLE;
    end else begin
      lag_q <= lag_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      qtr_q      <= QTR_FIRST;
      pend_qtr_q <= QTR_FIRST;
      lag_cnt_q  <= LAG_CNT_ZERO;
    end else if (quarter_tick) begin
      qtr_q      <= qtr_next_w;
      pend_qtr_q <= qtr_next_w;
      lag_cnt_q  <= lag_len_w;
    end else if (lag_q == RTCIO_LAG_WAIT) begin
      lag_cnt_q  <= lag_cnt_q - LAG_CNT_ONE;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wave_low_q <= 1'b0;
    end else if (lag_done_w) begin
      wave_low_q <= (cs_w == CS_2HZ) ? low_2hz_w : low_1hz_w;
    end
  end

  // ------------------------------------------------------------------
  // level mode events, counters already hold the new time
  // ------------------------------------------------------------------
  wire at_sec0_w  = (cal_now.sec == SEC_ZERO);
  wire at_hour_w  = at_sec0_w & (cal_now.min == MIN_ZERO);
  wire at_month_w = at_hour_w & (cal_now.hour == HOUR_ZERO)
                  & (cal_now.mday == MDAY_FIRST);
  logic level_hit_w;

  always_comb begin
    case (cs_w)
      CS_SEC:   level_hit_w = 1'b1;
      CS_MIN:   level_hit_w = at_sec0_w;
      CS_HOUR:  level_hit_w = at_hour_w;
      CS_MONTH: level_hit_w = at_month_w;
      default:  level_hit_w = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // periodic event flag
  // ------------------------------------------------------------------
  logic per_flag_q;
  logic per_flag_d;

  always_comb begin
    per_flag_d = per_flag_q;
    case (cs_w)
      CS_OFF: begin
        per_flag_d = 1'b0;
      end
      CS_LOW: begin
        per_flag_d = 1'b1;
      end
      CS_2HZ, CS_1HZ: begin
        per_flag_d = wave_low_q;
      end
      default: begin
        if (clr_per_w) begin
          per_flag_d = 1'b0;
        end
        if (sec_tick && level_hit_w) begin
          per_flag_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      per_flag_q <= 1'b0;
    end else begin
      per_flag_q <= per_flag_d;
    end
  end

  // ------------------------------------------------------------------
  // shared open-drain interrupt pin and flag readback
  // ------------------------------------------------------------------
  // wired or of sources
  wire any_src_w = alarm_flag_w[0] | alarm_flag_w[1] | per_flag_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_out_n_q <= 1'b0;
      interrupt_oe_n_q  <= 1'b1;
    end else begin
      interrupt_out_n_q <= 1'b0;
      interrupt_oe_n_q  <= ~any_src_w;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q.alarm_a_event_flag  <= alarm_flag_w[0];
      flags_q.alarm_b_event_flag  <= alarm_flag_w[1];
      flags_q.periodic_event_flag <= per_flag_q;
    end
  end

  logic [7:0] ctrl1_view_w;
  logic [7:0] ctrl2_view_w;

  always_comb begin
    ctrl1_view_w = REG_RESET;
    ctrl1_view_w[CTRL1_ALARM_A_EN_BIT] = cfg_q.alarm_a_enable;
    ctrl1_view_w[CTRL1_ALARM_B_EN_BIT] = cfg_q.alarm_b_enable;
    ctrl1_view_w[CTRL1_CYCLE_SEL_HI:CTRL1_CYCLE_SEL_LO] = cs_w;
    ctrl2_view_w = REG_RESET;
    ctrl2_view_w[CTRL2_CLK_OUT_DIS_BIT] = cfg_q.clock_output_disable;
    ctrl2_view_w[CTRL2_PERIODIC_BIT] = per_flag_q;
    ctrl2_view_w[CTRL2_ALARM_A_BIT]  = alarm_flag_w[0];
    ctrl2_view_w[CTRL2_ALARM_B_BIT]  = alarm_flag_w[1];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl1_rdata_q <= REG_RESET;
      ctrl2_rdata_q <= REG_RESET;
    end else begin
      ctrl1_rdata_q <= ctrl1_view_w;
      ctrl2_rdata_q <= ctrl2_view_w;
    end
  end

  // ------------------------------------------------------------------
  // raw oscillator clock output
  // ------------------------------------------------------------------
  logic osc_s1_q;
  logic osc_s2_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_s1_q <= 1'b1;
      osc_s2_q <= 1'b1;
    end else begin
      osc_s1_q <= osc_clk_pin;
      osc_s2_q <= osc_s1_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      raw_clock_out_q <= 1'b1;
    end else begin
      raw_clock_out_q <= cfg_q.clock_output_disable | osc_s2_q;
    end
  end

endmodule : rtcio_top

`default_nettype wire

// [tb/rtcio_sva.sv]
// port assertions for the rtc interrupt and clock-out logic
`default_nettype none

module rtcio_sva
  import rtcio_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         rstn,
  input wire logic         oscillator_halt_flag,
  input wire logic         osc_clk_pin,
  input wire logic         sec_tick,
  input wire rtcio_cal_s   cal_now,
  input wire rtcio_alarm_s alarm_a_time,
  input wire logic [7:0]   ctrl1_rdata_q,
  input wire logic [7:0]   ctrl2_rdata_q,
  input wire rtcio_flags_s flags_q,
  input wire logic         interrupt_out_n_q,
  input wire logic         interrupt_oe_n_q,
  input wire logic         raw_clock_out_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_q;
  logic       match_a;
  assign match_a = alarm_a_time == {cal_now.dow, cal_now.hour, cal_now.min};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  chk_halt_cfg_zero: assert property (
    oscillator_halt_flag |-> ##2 ctrl1_rdata_q == 8'h00 && !ctrl2_rdata_q[3])
    else $error("config not cleared by halt");
  chk_pin_open_drain: assert property (
    interrupt_out_n_q == 1'b0)
    else $error("interrupt pin value not low");
  chk_flag_inverse: assert property (
    flags_q.alarm_a_event_flag || flags_q.alarm_b_event_flag
    |-> !interrupt_oe_n_q)
    else $error("alarm flag set with pin released");
  chk_alarm_cause: assert property (
    $rose(flags_q.alarm_a_event_flag) |-> ctrl1_rdata_q[7] &&
    ($past(match_a, 1) || $past(match_a, 2) || $past(match_a, 3)))
    else $error("alarm flag rose without enabled match");
  chk_clk_disabled: assert property (
    ctrl2_rdata_q[3] |-> raw_clock_out_q)
    else $error("raw clock not held high");
  chk_clk_pass: assert property (
    up_q == 3'h7 && !ctrl2_rdata_q[3]
    |-> raw_clock_out_q == $past(osc_clk_pin, 3))
    else $error("raw clock not passed through");
  chk_fixed_low: assert property (
    (ctrl1_rdata_q[2:0] == CS_LOW) [*3] |-> !interrupt_oe_n_q)
    else $error("fixed low code left pin released");
  chk_off_quiet: assert property (
    (ctrl1_rdata_q == 8'h00) [*3] |-> interrupt_oe_n_q)
    else $error("pin low with all sources off");
  chk_level_tick: assert property (
    ctrl1_rdata_q[2:0] == CS_SEC && sec_tick && !oscillator_halt_flag
    |-> ##[1:3] !interrupt_oe_n_q)
    else $error("level mode missed seconds tick");
  cov_both_alarms: cover property (
    flags_q.alarm_a_event_flag && flags_q.alarm_b_event_flag);
  cov_pin_falls: cover property ($fell(interrupt_oe_n_q));
  cov_clk_off: cover property (ctrl2_rdata_q[3] && raw_clock_out_q);
endmodule : rtcio_sva

bind rtcio_top rtcio_sva rtcio_sva_i (.core_clk, .rstn,
  .oscillator_halt_flag, .osc_clk_pin, .sec_tick, .cal_now, .alarm_a_time,
  .ctrl1_rdata_q, .ctrl2_rdata_q, .flags_q, .interrupt_out_n_q,
  .interrupt_oe_n_q, .raw_clock_out_q);

`default_nettype wire

// [tb/rtcio_host_model.sv]
// host side: pulled-up interrupt line and request counter
`default_nettype none

module rtcio_host_model (
  input  wire logic       core_clk,
  input  wire logic       pin_out_n,
  input  wire logic       pin_oe_n,
  output wire logic       irq_line,
  output wire logic [7:0] irq_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       line_q = 1'b1;
  logic [7:0] seen_q = 8'h00;
  assign irq_line = pin_oe_n ? 1'b1 : pin_out_n;
  assign irq_seen = seen_q;
  always @(posedge core_clk) begin
    line_q <= irq_line;
    if (line_q && !irq_line) seen_q <= seen_q + 8'h01;
  end
endmodule : rtcio_host_model

`default_nettype wire

// [tb/rtcio_top_test.sv]
// self-checking bench for the rtc interrupt and clock-out logic
`default_nettype none

module rtcio_top_test;
  import rtcio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         core_clk, rstn, halt, xtal, sec_tick, q_tick;
  logic         osc = 1'b0;
  logic         c1_wr, c2_wr, out_n, oe_n, rclk, irq_line;
  logic [7:0]   c1_d, c2_d, r1, r2, irq_seen;
  rtcio_cal_s   cal;
  rtcio_alarm_s a_t, b_t;
  rtcio_flags_s flags;
  int           err_total, tests_run;
  wire logic [7:0] pin8 = {7'h00, irq_line};
  wire logic [7:0] flg8 = {5'h00, flags};

  rtcio_top rtcio_top_i (.core_clk(core_clk), .rstn(rstn),
    .oscillator_halt_flag(halt), .xtal_32000(xtal), .osc_clk_pin(osc),
    .sec_tick(sec_tick), .quarter_tick(q_tick), .cal_now(cal),
    .alarm_a_time(a_t), .alarm_b_time(b_t), .ctrl1_wr(c1_wr),
    .ctrl1_wdata(c1_d), .ctrl2_wr(c2_wr), .ctrl2_wdata(c2_d),
    .ctrl1_rdata_q(r1), .ctrl2_rdata_q(r2), .flags_q(flags),
    .interrupt_out_n_q(out_n), .interrupt_oe_n_q(oe_n),
    .raw_clock_out_q(rclk));
  rtcio_host_model rtcio_host_model_i (.core_clk(core_clk),
    .pin_out_n(out_n), .pin_oe_n(oe_n), .irq_line(irq_line),
    .irq_seen(irq_seen));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  always begin
    cyc(3);
    osc = ~osc;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr1(input logic [7:0] d);
    c1_wr = 1'b1;
    c1_d = d;
    cyc(1);
    c1_wr = 1'b0;
    cyc(3);
  endtask : wr1
  task automatic wr2(input logic [7:0] d);
    c2_wr = 1'b1;
    c2_d = d;
    cyc(1);
    c2_wr = 1'b0;
    cyc(3);
  endtask : wr2
  task automatic tick(input logic s);
    sec_tick = s;
    q_tick = 1'b1;
    cyc(1);
    sec_tick = 1'b0;
    q_tick = 1'b0;
  endtask : tick
  task automatic summarize;
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_halt_clock;
    int lo;
    check(pin8, 8'h01);
    halt = 1'b1;
    wr1(8'hC7);
    wr2(8'h08);
    check(r1, 8'h00);
    check(r2, 8'h00);
    halt = 1'b0;
    lo = 0;
    repeat (12) begin
      cyc(1);
      lo += int'(!rclk);
    end
    check(8'(lo != 0), 8'h01);
    wr2(8'h08);
    lo = 0;
    repeat (12) begin
      cyc(1);
      lo += int'(!rclk);
    end
    check(8'(lo), 8'h00);
    wr2(8'h00);
  endtask : t_halt_clock
  task automatic t_alarm;
    cal = '{3'h2, 6'h05, 6'h08, 7'h15, 7'h30};
    a_t = '{3'h2, 6'h08, 7'h15};
    b_t = a_t;
    wr1(8'h80);
    check(flg8, 8'h04);
    check(r2, 8'h02);
    check(pin8, 8'h00);
    wr1(8'hC0);
    check(r1, 8'hC0);
    check(r2, 8'h03);
    wr2(8'h01);
    check(r2, 8'h01);
    check(pin8, 8'h00);
    wr2(8'h03);
    check(r2, 8'h01);
    wr2(8'h00);
    cyc(4);
    check(r2, 8'h00);
    check(pin8, 8'h01);
    cal.min = 7'h16;
    cyc(2);
    cal.min = 7'h15;
    cyc(4);
    check(r2, 8'h03);
    wr1(8'h40);
    check(r2, 8'h01);
    wr1(8'h00);
    check(pin8, 8'h01);
  endtask : t_alarm
  task automatic t_level;
    for (int i = 0; i < 4; i++) begin
      wr1(8'h04 + 8'(i));
      cal = '{3'h3, 6'h02, 6'h01, 7'h01, 7'h01};
      if (i > 0) begin
        tick(1'b1);
        cyc(3);
        check(r2, 8'h00);
      end
      cal = '{3'h3, 6'h01, 6'h00, 7'h00, 7'h00};
      tick(1'b1);
      cyc(2);
      check(pin8, 8'h00);
      check(r2, 8'h04);
      wr2(8'h04);
      check(r2, 8'h04);
      wr2(8'h00);
      check(pin8, 8'h01);
    end
    wr1(8'h01);
    check(pin8, 8'h00);
    wr1(8'h00);
    cyc(2);
    check(pin8, 8'h01);
  endtask : t_level
  task automatic t_pulse(input logic [7:0] code, input logic x,
                         input int lag, input int nlow);
    xtal = x;
    wr1(code);
    tick(1'b1);
    cyc(lag - 10);
    check(pin8, 8'h01);
    cyc(30);
    check(pin8, 8'h00);
    check(r2, 8'h04);
    for (int j = 1; j < nlow; j++) begin
      tick(1'b0);
      cyc(lag + 20);
      check(pin8, 8'h00);
    end
    tick(1'b0);
    cyc(lag - 10);
    check(pin8, 8'h00);
    cyc(30);
    check(pin8, 8'h01);
    wr1(8'h00);
  endtask : t_pulse
  initial begin
    {halt, xtal, sec_tick, q_tick, c1_wr, c2_wr} = 6'h00;
    {c1_d, c2_d} = 16'h0000;
    cal = '0;
    a_t = '{3'h7, 6'h3F, 7'h7F};
    b_t = a_t;
    err_total = 0;
    tests_run = 0;
    rstn = 1'b0;
    cyc(8);
    rstn = 1'b1;
    t_halt_clock();
    t_alarm();
    t_level();
    t_pulse(CS_2HZ, 1'b0, 2300, 1);
    t_pulse(CS_1HZ, 1'b1, 2350, 2);
    check(8'(irq_seen != 8'h00), 8'h01);
    summarize();
  end
endmodule : rtcio_top_test

`default_nettype wire
